/* core/utf_transmitter.sv */
// Serial transmitter with frame format, AXI4-Lite registers and clock pins.
`timescale 1ns/1ps
`default_nettype none

module utf_transmitter #(
    parameter int unsigned ADDR_W = utf_pkg::ADDR_W,
    parameter int unsigned BAUD_W = utf_pkg::BAUD_W
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Serial output pin.
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    // Transfer clock pin.
    input wire logic transfer_clock_pin_i,
    output logic transfer_clock_pin_o,
    output logic transfer_clock_pin_oe,
    // Interrupt requests and acknowledge.
    output logic udre_irq_req,
    output logic txc_irq_req,
    input wire logic txc_irq_ack,
    // Shared format and receiver stop-bit report.
    output utf_pkg::utf_fmt_t fmt_o,
    input wire logic rx_stop_valid,
    input wire logic rx_first_stop
);

    ////////////////////////////////////////////////////////////////////////////
    // Whole module state.
    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic double_speed;
        logic clock_master;
        logic txc_ie;
        logic udre_ie;
        logic transmitter_on;
        logic ninth_tx_bit;
        utf_pkg::utf_fmt_t fmt;
        logic [BAUD_W-1:0] baud_divisor;
        logic baud_reload;
        logic buf_full;
        logic [8:0] buf_data;
        utf_pkg::utf_tx_state_t state;
        logic [utf_pkg::FRAME_W-1:0] shreg;
        logic [3:0] bits_left;
        logic tx_out;
        logic pin_oe;
        logic tx_complete_flag;
        logic udre_irq;
        logic txc_irq;
        logic [3:0] presc;
        logic xck_out;
        logic xck_oe;
        logic xck_prev;
        logic frame_error_flag;
    } utf_tx_regs_t;

    utf_tx_regs_t st_ff; // Registered state.
    utf_tx_regs_t nxt_st; // Next state.
    logic baud_tick; // One tick per baud counter underflow.

    ////////////////////////////////////////////////////////////////////////////
    // Data bits per character; reserved codes fall back to eight.
    function automatic logic [3:0] data_bits(input logic [2:0] cs);
        case (cs)
            3'h0: data_bits = 4'h5;
            3'h1: data_bits = 4'h6;
            3'h2: data_bits = 4'h7;
            utf_pkg::CS_NINE: data_bits = 4'h9;
            default: data_bits = 4'h8;
        endcase
    endfunction

    // Builds the frame: ones everywhere, then start, data and parity on top,
    // so unused upper positions are stop bits or never shifted.
    function automatic utf_pkg::utf_frame_t build_frame(input logic [8:0] d,
                                                        input utf_pkg::utf_fmt_t f);
        utf_pkg::utf_frame_t fr;
        logic [3:0] n;
        logic par;
        logic pen;
        fr.bits = '1;
        fr.bits[0] = 1'b0;
        n = data_bits(f.char_size_select);
        pen = f.parity_mode_select[1];
        par = (f.parity_mode_select == utf_pkg::PM_ODD);
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                fr.bits[i+1] = d[i];
                par = par ^ d[i];
            end
        end
        if (pen) begin
            fr.bits[4'(n + 4'h1)] = par;
        end
        fr.len = 4'(n + 4'h2 + {3'h0, pen} + {3'h0, f.stop_bits_select});
        return fr;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Baud rate generator.
    utf_baud_gen #(
        .BAUD_W(BAUD_W)
    ) u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .baud_divisor(st_ff.baud_divisor),
        .reload(st_ff.baud_reload),
        .tick(baud_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, registers, bit timing and shifter.
    always_comb begin
        logic active;
        logic strobe;
        logic do_load;
        logic sync_master;
        logic [3:0] div;
        logic [31:0] rd;
        logic rd_ok;
        utf_pkg::utf_frame_t fr;
        active = 1'b0;
        strobe = 1'b0;
        do_load = 1'b0;
        sync_master = 1'b0;
        div = utf_pkg::DIV_NORMAL;
        rd = 32'h0000_0000;
        rd_ok = 1'b1;
        fr = build_frame(st_ff.buf_data, st_ff.fmt);
        nxt_st = st_ff;
        nxt_st.baud_reload = 1'b0;

        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.w_data = s_axi_wdata;
            nxt_st.w_strb = s_axi_wstrb;
        end

        // Complete flag clears by acknowledge before any set below wins.
        if (txc_irq_ack) begin
            nxt_st.tx_complete_flag = 1'b0;
        end

        // Perform a write once both halves are held.
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = utf_pkg::RESP_OKAY;
            case (st_ff.aw_addr)
                utf_pkg::OFS_CSA: begin
                    // The empty flag position is read-only here.
                    if (st_ff.w_strb[0]) begin
                        nxt_st.double_speed = st_ff.w_data[utf_pkg::CSA_U2X];
                        if (st_ff.w_data[utf_pkg::CSA_TXC]) begin
                            nxt_st.tx_complete_flag = 1'b0;
                        end
                    end
                end
                utf_pkg::OFS_CSB: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.clock_master = st_ff.w_data[utf_pkg::CSB_XCKM];
                        nxt_st.txc_ie = st_ff.w_data[utf_pkg::CSB_TXCIE];
                        nxt_st.udre_ie = st_ff.w_data[utf_pkg::CSB_UDRIE];
                        nxt_st.transmitter_on = st_ff.w_data[utf_pkg::CSB_TXON];
                        nxt_st.ninth_tx_bit = st_ff.w_data[utf_pkg::CSB_NINTH_TX_BIT];
                    end
                end
                utf_pkg::OFS_CSC: begin
                    // No guard against live changes: traffic is corrupted.
                    if (st_ff.w_strb[0]) begin
                        nxt_st.fmt = st_ff.w_data[7:0];
                    end
                end
                utf_pkg::OFS_DATA: begin
                    // A write into a full buffer is dropped, not overwritten.
                    if (st_ff.w_strb[0] && !st_ff.buf_full) begin
                        nxt_st.buf_full = 1'b1;
                        nxt_st.buf_data = {st_ff.ninth_tx_bit, st_ff.w_data[7:0]};
                    end
                end
                utf_pkg::OFS_BAUD: begin
                    if (st_ff.w_strb[0]) begin
                        nxt_st.baud_divisor[7:0] = st_ff.w_data[7:0];
                        nxt_st.baud_reload = 1'b1;
                    end
                    if (st_ff.w_strb[1]) begin
                        nxt_st.baud_divisor[BAUD_W-1:8] = st_ff.w_data[BAUD_W-1:8];
                    end
                end
                default: begin
                    nxt_st.bresp = utf_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;

        // Read mux; unmapped addresses answer with an error and zero data.
        case (s_axi_araddr)
            utf_pkg::OFS_CSA: begin
                rd[utf_pkg::CSA_TXC] = st_ff.tx_complete_flag;
                rd[utf_pkg::CSA_UDRE] = !st_ff.buf_full;
                rd[utf_pkg::CSA_FE] = st_ff.frame_error_flag;
                rd[utf_pkg::CSA_U2X] = st_ff.double_speed;
            end
            utf_pkg::OFS_CSB: begin
                rd[utf_pkg::CSB_XCKM] = st_ff.clock_master;
                rd[utf_pkg::CSB_TXCIE] = st_ff.txc_ie;
                rd[utf_pkg::CSB_UDRIE] = st_ff.udre_ie;
                rd[utf_pkg::CSB_TXON] = st_ff.transmitter_on;
                rd[utf_pkg::CSB_NINTH_TX_BIT] = st_ff.ninth_tx_bit;
            end
            utf_pkg::OFS_CSC: rd[7:0] = st_ff.fmt;
            utf_pkg::OFS_DATA: rd = 32'h0000_0000;
            utf_pkg::OFS_BAUD: rd[BAUD_W-1:0] = st_ff.baud_divisor;
            default: rd_ok = 1'b0;
        endcase
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd;
            nxt_st.rresp = rd_ok ? utf_pkg::RESP_OKAY : utf_pkg::RESP_SLVERR;
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        // Ready follows the free answer slot, so it also comes up after reset.
        nxt_st.arready = !nxt_st.rvalid;

        // The transmitter stays live after disable until all data has gone.
        active = st_ff.transmitter_on || st_ff.buf_full
                 || (st_ff.state == utf_pkg::TX_SHIFT);
        sync_master = st_ff.fmt.sync_mode && st_ff.clock_master;

        // Bit strobe: divided baud ticks, own clock edges, or a peer's edge.
        nxt_st.xck_prev = transfer_clock_pin_i;
        if (!active) begin
            nxt_st.presc = 4'h0;
            nxt_st.xck_out = st_ff.fmt.clk_polarity;
        end else if (sync_master) begin
            if (baud_tick) begin
                nxt_st.xck_out = !st_ff.xck_out;
                strobe = (st_ff.xck_out == st_ff.fmt.clk_polarity);
            end
        end else if (st_ff.fmt.sync_mode) begin
            // Slave edge detect; the peer clock must stay below a quarter rate.
            strobe = (transfer_clock_pin_i != st_ff.xck_prev)
                     && (transfer_clock_pin_i != st_ff.fmt.clk_polarity);
        end else begin
            div = st_ff.double_speed ? utf_pkg::DIV_DOUBLE : utf_pkg::DIV_NORMAL;
            if (baud_tick) begin
                if (st_ff.presc >= div) begin
                    nxt_st.presc = 4'h0;
                    strobe = 1'b1;
                end else begin
                    nxt_st.presc = 4'(st_ff.presc + 4'h1);
                end
            end
        end
        if (sync_master && active) begin
            div = utf_pkg::DIV_SYNC;
        end
        nxt_st.xck_oe = sync_master && active;

        // Shifter: each strobe ends the current bit period.
        if (strobe && active) begin
            case (st_ff.state)
                utf_pkg::TX_IDLE: begin
                    do_load = st_ff.buf_full;
                end
                utf_pkg::TX_SHIFT: begin
                    if (st_ff.bits_left == 4'h0) begin
                        if (st_ff.buf_full) begin
                            do_load = 1'b1;
                        end else begin
                            nxt_st.state = utf_pkg::TX_IDLE;
                            nxt_st.tx_out = 1'b1;
                            nxt_st.tx_complete_flag = 1'b1;
                        end
                    end else begin
                        nxt_st.tx_out = st_ff.shreg[0];
                        nxt_st.shreg = {1'b1, st_ff.shreg[utf_pkg::FRAME_W-1:1]};
                        nxt_st.bits_left = st_ff.bits_left - 4'h1;
                    end
                end
                default: begin
                    nxt_st.state = utf_pkg::TX_IDLE;
                end
            endcase
        end
        if (do_load) begin
            nxt_st.state = utf_pkg::TX_SHIFT;
            nxt_st.tx_out = fr.bits[0];
            nxt_st.shreg = {1'b1, fr.bits[utf_pkg::FRAME_W-1:1]};
            nxt_st.bits_left = fr.len - 4'h1;
            nxt_st.buf_full = 1'b0;
        end
        if (!active) begin
            nxt_st.tx_out = 1'b1;
        end
        nxt_st.pin_oe = nxt_st.transmitter_on || nxt_st.buf_full
                        || (nxt_st.state == utf_pkg::TX_SHIFT);

        // Receiver report: only the first stop bit decides the error flag.
        if (rx_stop_valid) begin
            nxt_st.frame_error_flag = !rx_first_stop;
        end

        // Interrupt requests follow the flags and their enables.
        nxt_st.udre_irq = nxt_st.udre_ie && !nxt_st.buf_full;
        nxt_st.txc_irq = nxt_st.txc_ie && nxt_st.tx_complete_flag;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.fmt.char_size_select <= utf_pkg::CS_RST;
            st_ff.baud_divisor <= utf_pkg::BAUD_RST;
            st_ff.tx_out <= 1'b1;
            st_ff.xck_prev <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign serial_out_pin_o = st_ff.tx_out;
    assign serial_out_pin_oe = st_ff.pin_oe;
    assign transfer_clock_pin_o = st_ff.xck_out;
    assign transfer_clock_pin_oe = st_ff.xck_oe;
    assign udre_irq_req = st_ff.udre_irq;
    assign txc_irq_req = st_ff.txc_irq;
    assign fmt_o = st_ff.fmt;

endmodule

`default_nettype wire

/* pkg/utf_pkg.sv */
// Shared constants, register map and types of the serial transmitter block.
package utf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the AXI4-Lite slave.
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFS_CSA = 5'h00;
    localparam logic [4:0] OFS_CSB = 5'h04;
    localparam logic [4:0] OFS_CSC = 5'h08;
    localparam logic [4:0] OFS_DATA = 5'h0c;
    localparam logic [4:0] OFS_BAUD = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned CSA_TXC = 6;
    localparam int unsigned CSA_UDRE = 5;
    localparam int unsigned CSA_FE = 4;
    localparam int unsigned CSA_U2X = 1;
    localparam int unsigned CSB_XCKM = 7;
    localparam int unsigned CSB_TXCIE = 6;
    localparam int unsigned CSB_UDRIE = 5;
    localparam int unsigned CSB_TXON = 3;
    localparam int unsigned CSB_NINTH_TX_BIT = 0;
    localparam int unsigned CSC_POL = 7;
    localparam int unsigned CSC_SYNC = 6;
    localparam int unsigned CSC_PM = 4;
    localparam int unsigned CSC_SB = 3;
    localparam int unsigned CSC_CS = 0;
    localparam int unsigned BAUD_W = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and encodings.
    localparam logic [2:0] CS_RST = 3'h3;
    localparam logic [11:0] BAUD_RST = 12'h000;
    localparam logic [2:0] CS_NINE = 3'h7;
    localparam logic [1:0] PM_ODD = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Baud ticks per bit, minus one: normal, double speed, synchronous master.
    localparam logic [3:0] DIV_NORMAL = 4'hf;
    localparam logic [3:0] DIV_DOUBLE = 4'h7;
    localparam logic [3:0] DIV_SYNC = 4'h1;

    // Longest frame: start, nine data, parity, two stops.
    localparam int unsigned FRAME_W = 13;

    // Transmit shifter states.
    typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} utf_tx_state_t;

    // Frame format shared by transmitter and receiver.
    typedef struct packed {
        logic clk_polarity;
        logic sync_mode;
        logic [1:0] parity_mode_select;
        logic stop_bits_select;
        logic [2:0] char_size_select;
    } utf_fmt_t;

    // A fully built frame, bit 0 goes out first.
    typedef struct packed {
        logic [3:0] len;
        logic [FRAME_W-1:0] bits;
    } utf_frame_t;

endpackage

/* core/utf_baud_gen.sv */
// Baud rate down-counter producing one tick each time it reaches zero.
`timescale 1ns/1ps
`default_nettype none

module utf_baud_gen #(
    parameter int unsigned BAUD_W = 12
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Divisor and reload request.
    input wire logic [BAUD_W-1:0] baud_divisor,
    input wire logic reload,
    // One-cycle tick.
    output logic tick
);

    // Counter state and registered tick.
    typedef struct packed {
        logic [BAUD_W-1:0] cnt;
        logic tick;
    } utf_baud_state_t;

    utf_baud_state_t st_ff; // Registered state.
    utf_baud_state_t nxt_st; // Next state.

    // A write of the low divisor byte restarts the count so the new rate
    // starts cleanly instead of finishing the old period first.
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (reload) begin
            nxt_st.cnt = baud_divisor;
        end else if (st_ff.cnt == '0) begin
            nxt_st.cnt = baud_divisor;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule

`default_nettype wire

/* test/utf_tx_asserts.sv */
// Port assertions for the serial transmitter.
`timescale 1ns/1ps
`default_nettype none
module utf_tx_chk (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line, clock pin and format.
    input wire logic serial_out_pin_o,
    input wire logic transfer_clock_pin_oe,
    input wire utf_pkg::utf_fmt_t fmt_o
);
    // One domain, so clock and reset are given once.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("write address ready came back early");
    b_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not freed");
    r_time_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready) else $error("read not freed");
    fmt_rst_a: assert property ($rose(aresetn) |-> fmt_o == 8'h03)
        else $error("format reset value wrong");
    // Async bits last at least eight clocks, even at double speed.
    bit_len_a: assert property ($changed(serial_out_pin_o) && !fmt_o.sync_mode
        |=> $stable(serial_out_pin_o) [*7]) else $error("line bit too short");
    xck_quiet_a: assert property (!fmt_o.sync_mode [*2] |-> !transfer_clock_pin_oe)
        else $error("clock pin driven in async mode");
endmodule
bind utf_transmitter utf_tx_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .serial_out_pin_o,
    .transfer_clock_pin_oe, .fmt_o);
`default_nettype wire

/* test/utf_line_rx.sv */
// Far-end receiver model that captures frames off the serial line.
`timescale 1ns/1ps
`default_nettype none
module utf_line_rx #(
    parameter int BIT = 16
) (
    // Clock, line level, bit count after the start bit and double speed.
    input wire logic aclk,
    input wire logic line,
    input wire logic [3:0] nbits,
    input wire logic fast,
    // Transfer clock, held still since only async frames run.
    output logic xck
);
    // Captured frames, start bit in bit 0.
    logic [15:0] q[$];
    // Sample mid-bit from the falling start edge, LSB first.
    initial begin
        logic [15:0] v;
        int per;
        xck = 1'h0;
        forever begin
            @(posedge aclk);
            if (line === 1'h0) begin
                per = fast ? BIT / 2 : BIT;
                repeat (per / 2 - 1) @(posedge aclk);
                v = 16'h0;
                for (int i = 0; i <= nbits; i++) begin
                    v[i] = line;
                    if (i < nbits)
                        repeat (per) @(posedge aclk);
                end
                q.push_back(v);
            end
        end
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the serial transmitter.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Bench-driven inputs and watched outputs.
    logic aclk = 1'h0, aresetn = 1'h0, aw = 1'h0, w = 1'h0, ar = 1'h0;
    logic bready = 1'h0, rready = 1'h0, sv = 1'h0, fs = 1'h0, ack = 1'h0, ds = 1'h0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, so, soe, xck, xo, xoe, uirq, tirq;
    logic [3:0] nb = 4'h0;
    utf_pkg::utf_fmt_t fmt;
    int n_fail = 0, n_checks = 0, cyc = 0, seed = 79;
    always #25 aclk = ~aclk;
    utf_transmitter i_dut (.aclk, .aresetn, .s_axi_awvalid(aw), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(w), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(ar), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .serial_out_pin_o(so), .serial_out_pin_oe(soe),
        .transfer_clock_pin_i(xck), .transfer_clock_pin_o(xo), .transfer_clock_pin_oe(xoe),
        .udre_irq_req(uirq), .txc_irq_req(tirq), .txc_irq_ack(ack), .fmt_o(fmt),
        .rx_stop_valid(sv), .rx_first_stop(fs));
    // A released pin floats to its pull-up level.
    utf_line_rx i_rx (.aclk, .line(soe ? so : 1'h1), .nbits(nb), .fast(ds), .xck);
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Both channels offered at once; each released when taken.
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        aw <= 1'h1;
        w <= 1'h1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready)
                aw <= 1'h0;
            if (wready)
                w <= 1'h0;
        end while (!bvalid);
        chk(32'(bresp), 32'(utf_pkg::RESP_OKAY));
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] re);
        ar <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready)
                ar <= 1'h0;
        end while (!rvalid);
        chk(rdata, e);
        chk(32'(rresp), 32'(re));
    endtask
    // Expected line bits: start, data, optional parity, stops.
    function automatic logic [15:0] frame(input int cs, pm, sb, input logic [8:0] d);
        int n;
        logic p;
        logic [15:0] f;
        n = (cs == 7) ? 9 : cs + 5;
        p = pm[0];
        f = 16'h0;
        for (int i = 0; i < n; i++) begin
            f[i + 1] = d[i];
            p = p ^ d[i];
        end
        if (pm > 1) begin
            f[n + 1] = p;
            n++;
        end
        f[n + 1] = 1'h1;
        f[n + 2] = sb[0];
        return f;
    endfunction
    // Cuts a hang short; the run needs under 8000 cycles.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        int cs, pm, sb;
        logic [31:0] d1, d2, u;
        logic [15:0] e1, e2;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(utf_pkg::OFS_CSC, 32'h3, utf_pkg::RESP_OKAY);
        rd(5'h14, 32'h0, utf_pkg::RESP_SLVERR);
        for (int k = 0; k < 2; k++) begin
            sv <= 1'h1;
            fs <= k[0];
            @(posedge aclk);
            sv <= 1'h0;
            rd(utf_pkg::OFS_CSA, k ? 32'h20 : 32'h30, utf_pkg::RESP_OKAY);
        end
        wr(utf_pkg::OFS_BAUD, 32'h0);
        // Each pass: new format, two frames back to back, then disable.
        for (int i = 0; i < 10; i++) begin
            cs = (i % 5 == 4) ? 7 : i % 5;
            pm = (i % 3 == 0) ? 0 : i % 3 + 1;
            sb = i % 2;
            u = 32'(i / 5 * 2);
            d1 = $random(seed);
            d2 = $random(seed);
            e1 = frame(cs, pm, sb, d1[8:0]);
            e2 = frame(cs, pm, sb, d2[8:0]);
            nb <= 4'(((cs == 7) ? 9 : cs + 5) + pm / 2 + 1 + sb);
            ds <= 1'(i / 5);
            wr(utf_pkg::OFS_CSC, 32'(pm * 16 + sb * 8 + cs));
            chk(32'(fmt), 32'(pm * 16 + sb * 8 + cs));
            wr(utf_pkg::OFS_CSA, u);
            wr(utf_pkg::OFS_CSB, {24'h0, 7'h34, d1[8]});
            wr(utf_pkg::OFS_DATA, d1);
            repeat (20) @(posedge aclk);
            chk(32'(uirq & soe), 32'h1);
            wr(utf_pkg::OFS_CSB, {24'h0, 7'h34, d2[8]});
            wr(utf_pkg::OFS_DATA, d2);
            rd(utf_pkg::OFS_CSA, u, utf_pkg::RESP_OKAY);
            wr(utf_pkg::OFS_CSB, 32'h60);
            while (i_rx.q.size() < 2)
                @(posedge aclk);
            chk(32'(i_rx.q.pop_front()), 32'(e1));
            chk(32'(i_rx.q.pop_front()), 32'(e2));
            repeat (16) @(posedge aclk);
            chk(32'({soe, xo, xoe}), 32'h0);
            rd(utf_pkg::OFS_CSA, 32'h60 + u, utf_pkg::RESP_OKAY);
            chk(32'({uirq, tirq}), 32'h3);
            if (i % 2) begin
                ack <= 1'h1;
                @(posedge aclk);
                ack <= 1'h0;
            end else
                wr(utf_pkg::OFS_CSA, 32'h40 + u);
            rd(utf_pkg::OFS_CSA, 32'h20 + u, utf_pkg::RESP_OKAY);
        end
        final_report();
    end
endmodule
`default_nettype wire
